// [src/spsel_pkg.sv]
// Shared types and constants for the status pin and host port select block.
package spsel_pkg;

    // ------------------------------------------------------------------
    // Three-level pin decode
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LEVEL_LOW = 3'b001,
        LEVEL_MID = 3'b010,
        LEVEL_HIGH = 3'b100
    } spsel_level_e;

    // Comparator pair of one three-level pin: above a quarter and above three quarters of supply.
    typedef struct packed {
        logic aboveQuarter;
        logic aboveThreeQuarter;
    } spsel_tri_s;

    // One tristate or open-drain pin as seen from the logic; oeN low means the pin is driven.
    typedef struct packed {
        logic drive;
        logic oeN;
    } spsel_pin_s;

    // ------------------------------------------------------------------
    // Strap capture state machine
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        STRAP_WAIT = 2'b01,
        STRAP_DONE = 2'b10
    } spsel_strap_e;

    // ------------------------------------------------------------------
    // Encodings, positions and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] I2C_ADDR_UPPER = 4'hD;
    localparam logic HOST_MODE_I2C = 1'b0;
    localparam logic HOST_MODE_SPI = 1'b1;
    localparam logic SEL_MODE_MANUAL = 1'b0;
    localparam logic SEL_MODE_AUTO = 1'b1;
    localparam logic INPUT_ONE = 1'b0;
    localparam logic INPUT_TWO = 1'b1;
    localparam logic PIN_RELEASED = 1'b1;
    localparam logic PIN_DRIVEN = 1'b0;
    localparam int SYNC_WIDTH = 10;
    localparam int SYNC_RATE_LOW_Q = 0;
    localparam int SYNC_RATE_LOW_TQ = 1;
    localparam int SYNC_RATE_HIGH_Q = 2;
    localparam int SYNC_RATE_HIGH_TQ = 3;
    localparam int SYNC_SEL_PIN = 4;
    localparam int SYNC_SCL = 5;
    localparam int SYNC_SDA = 6;
    localparam int SYNC_SDI = 7;
    localparam int SYNC_STRAP0 = 8;
    localparam int SYNC_MODE = 9;
    // Rate comparators start at the middle pattern, so that leaving reset never shows a false low level.
    localparam logic [SYNC_WIDTH-1:0] SYNC_RESET_VALUE = 10'h005;
    localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h6;

endpackage

// [src/spsel_sync.sv]
// Three-stage pin synchroniser with a two-stage agreement filter, one lane per bit.
`timescale 1ns/1ps

module spsel_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Asynchronous pins
    input wire logic [WIDTH-1:0] pinIn,
    // Filtered levels in the clk_sys domain
    output logic [WIDTH-1:0] levelOut
);

    // ------------------------------------------------------------------
    // Per-bit synchroniser lanes
    // ------------------------------------------------------------------
    // The first stage feeds only the second; the filter looks at stages two and three.
    genvar bitIdx;
    generate
        for (bitIdx = 0; bitIdx < WIDTH; bitIdx++) begin : gLane
            logic stage1_reg;
            logic stage2_reg;
            logic stage3_reg;
            logic level_reg;
            wire logic agree = (stage2_reg == stage3_reg);
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    stage1_reg <= RESET_VALUE[bitIdx];
                    stage2_reg <= RESET_VALUE[bitIdx];
                    stage3_reg <= RESET_VALUE[bitIdx];
                    level_reg <= RESET_VALUE[bitIdx];
                end else begin
                    stage1_reg <= pinIn[bitIdx];
                    stage2_reg <= stage1_reg;
                    stage3_reg <= stage2_reg;
                    if (agree) begin
                        level_reg <= stage3_reg;
                    end
                end
            end
            assign levelOut[bitIdx] = level_reg;
        end
    endgenerate

endmodule

// [src/spsel_top.sv]
// Status pins, shared clock select pin and host serial port pin assignment.
`timescale 1ns/1ps

// Behaviour
// - Each rate pin decodes to low, middle or high; undriven reads middle.
// - Lock output enabled drives the indicator: 0 locked, 1 unlocked at polarity 1.
// - Lock output disabled leaves the lock pin undriven.
// - Lock polarity setting inverts or passes the lock pin level.
// - Lock state always shows on a read-only status bit.
// - Manual mode with pin enabled: pin 0 picks input one, 1 input two.
// - Pin select disabled: manual choice comes from the select bit, pin ignored.
// - Auto mode with pin enabled drives active input: 0 one, 1 two.
// - In hold with both alarms, active indication keeps the last used input.
// - Active pin disabled leaves the shared pin undriven.
// - Active indication always shows on a read-only status bit.
// - Serial clock pin is the host port clock in both modes.
// - Mode 0 runs the shared data pin as bidirectional open-drain data.
// - Mode 1 uses the shared data pin only as data output.
// - Bus address is 1101 then the three strap levels, top strap first.
// - In SPI mode the two low straps are ignored.
// - Third strap is top address bit in I2C, slave select in SPI.
// - SPI data-in pin carries host data in SPI, ignored in I2C.

module spsel_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Reference rate select pins
    input wire spsel_pkg::spsel_tri_s refRateSelLowPin,
    input wire spsel_pkg::spsel_tri_s refRateSelHighPin,
    output spsel_pkg::spsel_level_e refRateLowLevel,
    output spsel_pkg::spsel_level_e refRateHighLevel,
    // Lock indicator
    input wire logic pllUnlocked,
    input wire logic lockOutPinEnable,
    input wire logic lockOutPolarity,
    output spsel_pkg::spsel_pin_s lockLossOutPin,
    output logic lockLossStatusBit,
    // Input clock selection
    input wire logic clkSelMode,
    input wire logic manualSelPinEnable,
    input wire logic manualSelBit,
    input wire logic activeOutPinEnable,
    input wire logic autoChoiceTwo,
    input wire logic inputClockOneAlarm,
    input wire logic inputClockTwoAlarm,
    input wire logic clkSelOrActivePinIn,
    output spsel_pkg::spsel_pin_s clkSelOrActivePin,
    output logic selectInputTwo,
    output logic activeInputStatusBit,
    // Host port pins
    input wire logic hostSclPin,
    input wire logic sharedSerialDataPinIn,
    input wire logic spiDataInPin,
    input wire logic addrStrapBit0,
    input wire logic addrStrapBit1,
    input wire logic addrStrap2OrSelectPin,
    input wire logic hostPortModePin,
    output spsel_pkg::spsel_pin_s sharedSerialDataPin,
    // Host port towards the protocol engine
    input wire logic hostTxBit,
    input wire logic hostTxEnable,
    output logic hostModeSpi,
    output logic hostStrapsValid,
    output logic [6:0] i2cAddress,
    output logic spiSelectN,
    output logic hostSclLevel,
    output logic hostSclRise,
    output logic hostSclFall,
    output logic hostDataIn
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Strap 1 and strap 2 ride in a separate two-bit synchroniser; strap 2 sits above strap 1.
    logic [spsel_pkg::SYNC_WIDTH-1:0] syncIn;
    logic [spsel_pkg::SYNC_WIDTH-1:0] syncLevel;
    logic strap1Level;
    logic strap2Level;

    assign syncIn = {hostPortModePin, addrStrapBit0, spiDataInPin, sharedSerialDataPinIn, hostSclPin,
                     clkSelOrActivePinIn, refRateSelHighPin.aboveThreeQuarter, refRateSelHighPin.aboveQuarter,
                     refRateSelLowPin.aboveThreeQuarter, refRateSelLowPin.aboveQuarter};

    spsel_sync #(
        .WIDTH(spsel_pkg::SYNC_WIDTH),
        .RESET_VALUE(spsel_pkg::SYNC_RESET_VALUE)
    ) uSyncMain (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pinIn(syncIn),
        .levelOut(syncLevel)
    );

    spsel_sync #(
        .WIDTH(2),
        .RESET_VALUE(2'h0)
    ) uSyncStraps (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pinIn({addrStrap2OrSelectPin, addrStrapBit1}),
        .levelOut({strap2Level, strap1Level})
    );

    wire logic selPinLevel = syncLevel[spsel_pkg::SYNC_SEL_PIN];
    wire logic sclLevel = syncLevel[spsel_pkg::SYNC_SCL];
    wire logic sdaLevel = syncLevel[spsel_pkg::SYNC_SDA];
    wire logic sdiLevel = syncLevel[spsel_pkg::SYNC_SDI];
    wire logic strap0Level = syncLevel[spsel_pkg::SYNC_STRAP0];
    wire logic modeLevel = syncLevel[spsel_pkg::SYNC_MODE];

    // ------------------------------------------------------------------
    // Three-level rate decode
    // ------------------------------------------------------------------
    // Pull-up and pull-down park a floating pin at half supply, so only a firm drive leaves middle.
    // A pin that trips the upper comparator without the lower one is treated as middle.
    function automatic spsel_pkg::spsel_level_e decodeLevel(input logic aboveQ, input logic aboveTq);
        spsel_pkg::spsel_level_e lvl;
        lvl = spsel_pkg::LEVEL_MID;
        if (!aboveQ && !aboveTq) begin
            lvl = spsel_pkg::LEVEL_LOW;
        end else if (aboveQ && aboveTq) begin
            lvl = spsel_pkg::LEVEL_HIGH;
        end
        return lvl;
    endfunction

    spsel_pkg::spsel_level_e rateLow_reg;
    spsel_pkg::spsel_level_e rateHigh_reg;
    wire spsel_pkg::spsel_level_e rateLow_next = decodeLevel(syncLevel[spsel_pkg::SYNC_RATE_LOW_Q],
                                                             syncLevel[spsel_pkg::SYNC_RATE_LOW_TQ]);
    wire spsel_pkg::spsel_level_e rateHigh_next = decodeLevel(syncLevel[spsel_pkg::SYNC_RATE_HIGH_Q],
                                                              syncLevel[spsel_pkg::SYNC_RATE_HIGH_TQ]);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rateLow_reg <= spsel_pkg::LEVEL_MID;
            rateHigh_reg <= spsel_pkg::LEVEL_MID;
        end else begin
            rateLow_reg <= rateLow_next;
            rateHigh_reg <= rateHigh_next;
        end
    end

    assign refRateLowLevel = rateLow_reg;
    assign refRateHighLevel = rateHigh_reg;

    // ------------------------------------------------------------------
    // Lock indicator
    // ------------------------------------------------------------------
    spsel_pkg::spsel_pin_s lockPin_reg;
    logic lockStatus_reg;
    // Polarity at 1 keeps the pin active high; at 0 the unlocked state shows as low.
    wire logic lockLevel_next = lockOutPolarity ? pllUnlocked : !pllUnlocked;
    wire logic lockOeN_next = lockOutPinEnable ? spsel_pkg::PIN_DRIVEN : spsel_pkg::PIN_RELEASED;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lockPin_reg <= '{drive: 1'b0, oeN: spsel_pkg::PIN_RELEASED};
            lockStatus_reg <= 1'b0;
        end else begin
            lockPin_reg <= '{drive: lockLevel_next, oeN: lockOeN_next};
            lockStatus_reg <= pllUnlocked;
        end
    end

    assign lockLossOutPin = lockPin_reg;
    assign lockLossStatusBit = lockStatus_reg;

    // ------------------------------------------------------------------
    // Input clock selection and active indication
    // ------------------------------------------------------------------
    wire logic modeAuto = (clkSelMode == spsel_pkg::SEL_MODE_AUTO);
    wire logic manualChoice = manualSelPinEnable ? selPinLevel : manualSelBit;
    wire logic bothAlarmed = inputClockOneAlarm && inputClockTwoAlarm;
    // In hold the automatic choice is meaningless, so the last used input is kept instead.
    wire logic holdIndication = modeAuto && bothAlarmed;
    wire logic select_next = modeAuto ? autoChoiceTwo : manualChoice;

    logic select_reg;
    logic active_reg;
    spsel_pkg::spsel_pin_s selPin_reg;
    wire logic selOeN_next = (modeAuto && activeOutPinEnable) ? spsel_pkg::PIN_DRIVEN
                                                             : spsel_pkg::PIN_RELEASED;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            select_reg <= spsel_pkg::INPUT_ONE;
            active_reg <= spsel_pkg::INPUT_ONE;
        end else begin
            if (!holdIndication) begin
                select_reg <= select_next;
                active_reg <= select_next;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            selPin_reg <= '{drive: 1'b0, oeN: spsel_pkg::PIN_RELEASED};
        end else begin
            selPin_reg <= '{drive: active_reg, oeN: selOeN_next};
        end
    end

    assign clkSelOrActivePin = selPin_reg;
    assign selectInputTwo = select_reg;
    assign activeInputStatusBit = active_reg;

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // Straps and mode are caught once the synchronisers have settled after reset release.
    // The mode pin is trusted to be tied firmly; a floating one would pick a random port.
    spsel_pkg::spsel_strap_e strapState_reg;
    spsel_pkg::spsel_strap_e strapState_next;
    logic [2:0] settleCount_reg;
    logic modeSpi_reg;
    logic [2:0] strapAddr_reg;
    wire logic settleDone = (settleCount_reg == spsel_pkg::STRAP_SETTLE_CYCLES);

    always_comb begin
        strapState_next = strapState_reg;
        case (strapState_reg)
            spsel_pkg::STRAP_WAIT: begin
                if (settleDone) begin
                    strapState_next = spsel_pkg::STRAP_DONE;
                end
            end
            spsel_pkg::STRAP_DONE: begin
                strapState_next = spsel_pkg::STRAP_DONE;
            end
            default: begin
                strapState_next = spsel_pkg::STRAP_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strapState_reg <= spsel_pkg::STRAP_WAIT;
            settleCount_reg <= 3'h0;
        end else begin
            strapState_reg <= strapState_next;
            if (!settleDone) begin
                settleCount_reg <= settleCount_reg + 3'h1;
            end
        end
    end

    wire logic captureStraps = (strapState_reg == spsel_pkg::STRAP_WAIT) && settleDone;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            modeSpi_reg <= spsel_pkg::HOST_MODE_I2C;
            strapAddr_reg <= 3'h0;
        end else if (captureStraps) begin
            modeSpi_reg <= modeLevel;
            strapAddr_reg <= {strap2Level, strap1Level, strap0Level};
        end
    end

    wire logic strapsValid = (strapState_reg == spsel_pkg::STRAP_DONE);
    // The low straps only reach the address, which means nothing while the port runs SPI.
    wire logic [6:0] address_next = modeSpi_reg ? {spsel_pkg::I2C_ADDR_UPPER, 3'h0}
                                                : {spsel_pkg::I2C_ADDR_UPPER, strapAddr_reg};

    // ------------------------------------------------------------------
    // Host serial port pins
    // ------------------------------------------------------------------
    wire logic modeSpi = strapsValid && modeSpi_reg;
    wire logic modeI2c = strapsValid && !modeSpi_reg;
    wire logic spiSel_next = modeSpi ? strap2Level : 1'b1;
    wire logic dataIn_next = modeSpi ? sdiLevel : sdaLevel;
    // I2C pulls low only and lets the line float high; SPI pushes both levels while selected.
    wire logic sdaOeN_next = (modeI2c && hostTxEnable && !hostTxBit) ||
                             (modeSpi && hostTxEnable && !strap2Level) ? spsel_pkg::PIN_DRIVEN
                                                                       : spsel_pkg::PIN_RELEASED;
    wire logic sdaDrive_next = modeSpi ? hostTxBit : 1'b0;

    logic sclLevel_reg;
    logic sclRise_reg;
    logic sclFall_reg;
    logic dataIn_reg;
    logic spiSel_reg;
    logic [6:0] address_reg;
    logic strapsValid_reg;
    logic modeOut_reg;
    spsel_pkg::spsel_pin_s sdaPin_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sclLevel_reg <= 1'b0;
            sclRise_reg <= 1'b0;
            sclFall_reg <= 1'b0;
            dataIn_reg <= 1'b0;
            spiSel_reg <= 1'b1;
        end else begin
            sclLevel_reg <= sclLevel;
            sclRise_reg <= sclLevel && !sclLevel_reg;
            sclFall_reg <= !sclLevel && sclLevel_reg;
            dataIn_reg <= dataIn_next;
            spiSel_reg <= spiSel_next;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            address_reg <= 7'h00;
            strapsValid_reg <= 1'b0;
            modeOut_reg <= spsel_pkg::HOST_MODE_I2C;
            sdaPin_reg <= '{drive: 1'b0, oeN: spsel_pkg::PIN_RELEASED};
        end else begin
            address_reg <= address_next;
            strapsValid_reg <= strapsValid;
            modeOut_reg <= modeSpi;
            sdaPin_reg <= '{drive: sdaDrive_next, oeN: sdaOeN_next};
        end
    end

    assign hostSclLevel = sclLevel_reg;
    assign hostSclRise = sclRise_reg;
    assign hostSclFall = sclFall_reg;
    assign hostDataIn = dataIn_reg;
    assign spiSelectN = spiSel_reg;
    assign i2cAddress = address_reg;
    assign hostStrapsValid = strapsValid_reg;
    assign hostModeSpi = modeOut_reg;
    assign sharedSerialDataPin = sdaPin_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    lock_pin_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !lockOutPinEnable |=> lockLossOutPin.oeN == spsel_pkg::PIN_RELEASED)
        else $error("Lock pin driven while disabled.");

    lock_unlocked_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        lockOutPinEnable && lockOutPolarity && pllUnlocked |=> !lockLossOutPin.oeN && lockLossOutPin.drive)
        else $error("Lock pin does not show unlocked.");

    lock_polarity_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !lockOutPolarity |=> lockLossOutPin.drive == !$past(pllUnlocked))
        else $error("Lock pin polarity not inverted.");

    lock_status_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $changed(pllUnlocked) |=> lockLossStatusBit == $past(pllUnlocked)
        ##1 lockLossStatusBit == $past(pllUnlocked))
        else $error("Lock status bit does not follow lock state.");

    manual_pin_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !clkSelMode && manualSelPinEnable |=> selectInputTwo == $past(selPinLevel))
        else $error("Manual pin choice not applied.");

    manual_bit_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !clkSelMode && !manualSelPinEnable |=> selectInputTwo == $past(manualSelBit))
        else $error("Manual select bit not applied.");

    hold_keeps_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clkSelMode && inputClockOneAlarm && inputClockTwoAlarm |=> $stable(activeInputStatusBit))
        else $error("Active indication moved during hold.");

    active_drive_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clkSelMode && activeOutPinEnable |=> !clkSelOrActivePin.oeN
        && clkSelOrActivePin.drive == $past(activeInputStatusBit))
        else $error("Active pin not driven with the active input.");

    select_dir_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !clkSelMode || !activeOutPinEnable |=> clkSelOrActivePin.oeN == spsel_pkg::PIN_RELEASED)
        else $error("Shared select pin driven while input or disabled.");

    i2c_address_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        hostStrapsValid && !hostModeSpi |-> i2cAddress == {spsel_pkg::I2C_ADDR_UPPER, strapAddr_reg})
        else $error("Bus address not formed from the straps.");

    spi_data_in_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        modeSpi |=> hostDataIn == $past(sdiLevel))
        else $error("SPI data not taken from the data-in pin.");

    scl_edge_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sclLevel && !sclLevel_reg |=> hostSclRise ##1 !hostSclRise)
        else $error("Serial clock rise not reported once.");

endmodule

// [tb/spsel_host_model.sv]
// Host controller model driving the serial clock and the SPI data line.
`timescale 1ns/1ps

module spsel_host_model (
    // Frame control from the bench
    input wire logic frameOn,
    input wire logic sdiBit,
    // Host port pins
    output logic hostSclPin,
    output logic spiDataInPin
);
    // The clock stands low between frames, where the pull-down leaves it.
    // The odd start offset keeps its edges away from the system clock edges.
    initial begin
        hostSclPin = 1'h0;
        #17;
        forever #40 hostSclPin = frameOn ? ~hostSclPin : 1'h0;
    end
    // A released data line falls to its pull-down level.
    assign spiDataInPin = frameOn ? sdiBit : 1'h0;
endmodule

// [tb/status_pins_and_host_port_select_test.sv]
// Self-checking bench for the status pin and host port select block.
`timescale 1ns/1ps

module status_pins_and_host_port_select_test;
    logic clk_sys = 1'h0, arst_n = 1'h0, pllUnlocked = 1'h0, lockOutPinEnable = 1'h0, lockOutPolarity = 1'h0;
    logic clkSelMode = 1'h0, manualSelPinEnable = 1'h0, manualSelBit = 1'h0, activeOutPinEnable = 1'h0;
    logic autoChoiceTwo = 1'h0, inputClockOneAlarm = 1'h0, inputClockTwoAlarm = 1'h0, boardSel = 1'h1;
    logic addrStrapBit0 = 1'h0, addrStrapBit1 = 1'h0, addrStrap2OrSelectPin = 1'h0, hostPortModePin = 1'h0;
    logic hostTxBit = 1'h0, hostTxEnable = 1'h0, hostSda = 1'h1, frameOn = 1'h0, sdiBit = 1'h0;
    logic clkSelOrActivePinIn, selectInputTwo, activeInputStatusBit, hostSclPin, sharedSerialDataPinIn;
    logic spiDataInPin, hostModeSpi, hostStrapsValid, spiSelectN, hostSclLevel, hostSclRise, hostSclFall;
    logic hostDataIn, lockLossStatusBit;
    logic [6:0] i2cAddress;
    spsel_pkg::spsel_tri_s refRateSelLowPin = 2'h0, refRateSelHighPin = 2'h0;
    spsel_pkg::spsel_level_e refRateLowLevel, refRateHighLevel;
    spsel_pkg::spsel_pin_s lockLossOutPin, clkSelOrActivePin, sharedSerialDataPin;
    int nMismatch = 0, testsRun = 0, sclRises = 0, sclFalls = 0;

    always #2.5 clk_sys = ~clk_sys;
    // The board holds the shared select pin firm whenever the device releases it.
    assign clkSelOrActivePinIn = clkSelOrActivePin.oeN ? boardSel : clkSelOrActivePin.drive;
    assign sharedSerialDataPinIn = (sharedSerialDataPin.oeN | sharedSerialDataPin.drive) & hostSda;
    always @(posedge clk_sys) if (hostSclRise === 1'h1) sclRises++;
    always @(posedge clk_sys) if (hostSclFall === 1'h1) sclFalls++;

    spsel_host_model spsel_host_model_inst (.frameOn, .sdiBit, .hostSclPin, .spiDataInPin);
    spsel_top spsel_top_inst (.clk_sys, .arst_n, .refRateSelLowPin, .refRateSelHighPin, .refRateLowLevel,
        .refRateHighLevel, .pllUnlocked, .lockOutPinEnable, .lockOutPolarity, .lockLossOutPin, .lockLossStatusBit,
        .clkSelMode, .manualSelPinEnable, .manualSelBit, .activeOutPinEnable, .autoChoiceTwo, .inputClockOneAlarm,
        .inputClockTwoAlarm, .clkSelOrActivePinIn, .clkSelOrActivePin, .selectInputTwo, .activeInputStatusBit,
        .hostSclPin, .sharedSerialDataPinIn, .spiDataInPin, .addrStrapBit0, .addrStrapBit1, .addrStrap2OrSelectPin,
        .hostPortModePin, .sharedSerialDataPin, .hostTxBit, .hostTxEnable, .hostModeSpi, .hostStrapsValid,
        .i2cAddress, .spiSelectN, .hostSclLevel, .hostSclRise, .hostSclFall, .hostDataIn);

    task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
        testsRun++;
        if (g !== e) begin
            nMismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic st(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wrap_up;
        if (nMismatch == 0 && testsRun > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Straps and the mode pin are set while reset holds, so they are firm at capture.
    task automatic rst(input logic m, input logic [2:0] s);
        arst_n = 1'h0;
        hostPortModePin = m;
        {addrStrap2OrSelectPin, addrStrapBit1, addrStrapBit0} = s;
        st(20);
        arst_n = 1'h1;
        for (int i = 0; i < 20 && hostStrapsValid !== 1'h1; i++) st(1);
        if (hostStrapsValid !== 1'h1) begin
            nMismatch++;
            wrap_up;
        end
    endtask
    function automatic logic [6:0] lvl(input int i);
        return i == 0 ? 7'h1 : (i == 3 ? 7'h4 : 7'h2);
    endfunction

    initial begin
        rst(1'h0, 3'h5);
        chk("addr", 7'h6D, i2cAddress);
        chk("spi", 7'h0, hostModeSpi);
        chk("ssn", 7'h1, spiSelectN);
        for (int i = 0; i < 4; i++) begin
            refRateSelLowPin = i[1:0];
            refRateSelHighPin = ~i[1:0];
            st(8);
            chk("rlo", lvl(i), refRateLowLevel);
            chk("rhi", lvl(3 - i), refRateHighLevel);
        end
        for (int i = 0; i < 8; i++) begin
            {lockOutPinEnable, lockOutPolarity, pllUnlocked} = i[2:0];
            st(2);
            chk("loloe", !i[2], lockLossOutPin.oeN);
            if (i[2]) chk("lol", i[1] == i[0], lockLossOutPin.drive);
            chk("lolst", i[0], lockLossStatusBit);
        end
        manualSelPinEnable = 1'h1;
        st(8);
        chk("sel2", 7'h1, selectInputTwo);
        chk("csoe", 7'h1, clkSelOrActivePin.oeN);
        chk("act", 7'h1, activeInputStatusBit);
        boardSel = 1'h0;
        st(8);
        chk("sel2", 7'h0, selectInputTwo);
        manualSelPinEnable = 1'h0;
        manualSelBit = 1'h1;
        st(8);
        chk("sel2", 7'h1, selectInputTwo);
        clkSelMode = 1'h1;
        activeOutPinEnable = 1'h1;
        autoChoiceTwo = 1'h1;
        st(4);
        chk("csoe", 7'h0, clkSelOrActivePin.oeN);
        chk("csdr", 7'h1, clkSelOrActivePin.drive);
        inputClockOneAlarm = 1'h1;
        inputClockTwoAlarm = 1'h1;
        autoChoiceTwo = 1'h0;
        st(4);
        chk("csdr", 7'h1, clkSelOrActivePin.drive);
        activeOutPinEnable = 1'h0;
        st(4);
        chk("csoe", 7'h1, clkSelOrActivePin.oeN);
        chk("act", 7'h1, activeInputStatusBit);
        hostTxEnable = 1'h1;
        st(8);
        chk("sdoe", 7'h0, sharedSerialDataPin.oeN);
        chk("sddr", 7'h0, sharedSerialDataPin.drive);
        chk("din", 7'h0, hostDataIn);
        hostTxBit = 1'h1;
        st(8);
        chk("sdoe", 7'h1, sharedSerialDataPin.oeN);
        chk("din", 7'h1, hostDataIn);
        hostSda = 1'h0;
        st(8);
        chk("din", 7'h0, hostDataIn);
        hostSda = 1'h1;
        frameOn = 1'h1;
        st(64);
        frameOn = 1'h0;
        st(20);
        chk("rises", 7'h4, sclRises[6:0]);
        chk("falls", 7'h4, sclFalls[6:0]);
        chk("scl", 7'h0, hostSclLevel);
        rst(1'h1, 3'h3);
        chk("addr", 7'h68, i2cAddress);
        chk("spi", 7'h1, hostModeSpi);
        chk("ssn", 7'h0, spiSelectN);
        st(2);
        chk("sdoe", 7'h0, sharedSerialDataPin.oeN);
        chk("sddr", 7'h1, sharedSerialDataPin.drive);
        hostTxBit = 1'h0;
        st(2);
        chk("sddr", 7'h0, sharedSerialDataPin.drive);
        chk("sdoe", 7'h0, sharedSerialDataPin.oeN);
        frameOn = 1'h1;
        sdiBit = 1'h1;
        st(8);
        chk("din", 7'h1, hostDataIn);
        frameOn = 1'h0;
        addrStrap2OrSelectPin = 1'h1;
        st(8);
        chk("din", 7'h0, hostDataIn);
        chk("ssn", 7'h1, spiSelectN);
        chk("sdoe", 7'h1, sharedSerialDataPin.oeN);
        wrap_up;
    end
endmodule
